/* File: include/cpxcs_pkg.sv */
// Purpose: Shared constants and types for the copper extended control block.
// Assumes: AXI4-Lite slave, 32-bit data, one word per register.
// Notes:   Register offsets count words; CTRL_BYTE_ADDR and STATUS_BYTE_ADDR are byte addresses.
package cpxcs_pkg;
	localparam logic [15:0] CTRL_OFFSET   = 16'hFFF0;
	localparam logic [15:0] STATUS_OFFSET = 16'hFFF1;
	localparam logic [15:0] CTRL_BYTE_ADDR   = 16'hFFC0;
	localparam logic [15:0] STATUS_BYTE_ADDR = 16'hFFC4;
	localparam int BIT_NO_XOVER   = 14;
	localparam int BIT_TX_DIS     = 13;
	localparam int BIT_BYP_4B5B   = 10;
	localparam int BIT_BYP_SCR    = 9;
	localparam int BIT_BYP_MLT3   = 8;
	localparam int BIT_BYP_ALIGN  = 7;
	localparam int BIT_SCR_RST    = 6;
	localparam int BIT_LED_TRAF   = 5;
	localparam int BIT_LED_ON     = 4;
	localparam int BIT_LED_OFF    = 3;
	localparam int BIT_FIFO_LSB   = 0;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_WMASK     = 16'h67B9;
	localparam logic [15:0] STATUS_LIVE_RESET = 16'h0000;
	localparam logic [1:0]  AXI_OKAY   = 2'h0;
	localparam logic [1:0]  AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic no_auto_xover;
		logic tx_disable;
		logic bypass_4b5b;
		logic bypass_scrambler;
		logic bypass_mlt3;
		logic bypass_align;
		logic scrambler_load;
		logic led_traffic;
		logic led_on;
		logic led_off;
		logic fifo_elast_lsb;
	} cpxcs_ctrl_t;

	typedef struct packed {
		logic selector_mismatch;
		logic carrier_ext_err;
		logic bad_ssd;
		logic bad_esd;
		logic invalid_code;
		logic tx_err_code;
		logic lock_lost;
		logic mlt3_err;
		logic crc_err;
	} cpxcs_events_t;

	typedef struct packed {
		logic speed_downgraded;
		logic crossover_mdi;
		logic remote_rx_ok;
		logic local_rx_ok;
		logic descr_locked;
		logic link_pass;
	} cpxcs_live_t;
endpackage

/* File: core/cpxcs_regs.sv */
// Purpose: Control and status register pair for the copper extended path.
// Assumes: Events and live status arrive synchronous to aclk.
// Notes:   Status reads clear latched bits; see the hand-over for timing.
//
// How it works
// [RULE_01] Control bit 14 disables automatic crossover.
// [RULE_02] Control bit 13 tristates all line pairs.
// [RULE_03] Bit 10 passes raw 5B transmit codes.
// [RULE_04] 4B/5B bypass delivers 5B receive codes.
// [RULE_05] Bit 9 disables scrambler and descrambler.
// [RULE_06] Bit 8 bypasses MLT3, sending NRZ.
// [RULE_07] Bit 7 skips receive symbol alignment.
// [RULE_08] Bit 6 loads scrambler ones, self-clears.
// [RULE_09] Bit 5 enables LED traffic mode.
// [RULE_10] Bit 4 forces all LEDs on.
// [RULE_11] Bit 3 forces all LEDs off.
// [RULE_12] Software read-modify-writes reserved control bits.
// [RULE_13] Bit 0 holds FIFO elasticity low bit.
// [RULE_14] Status 15 latches selector mismatch until read.
// [RULE_15] Status 14 shows speed downgrade.
// [RULE_16] Status 13 shows crossover MDI mode.
// [RULE_17] Status 11,10 receiver OK latch low.
// [RULE_18] Status 9 lock, 8 link, live.
// [RULE_19] Status 7 holds CRC error until read.
// [RULE_20] Status 6..4 latch extension, delimiter errors.
// [RULE_21] Status 3..1 latch code, lock errors.
// [RULE_22] Status 0 latches MLT3 code error.
// [RULE_23] Force-off wins over force-on.
// [RULE_24] Event in read cycle beats the clear.
module cpxcs_regs (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    clk_en,
	input  wire logic [15:0]             s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [15:0]             s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire cpxcs_pkg::cpxcs_events_t events,
	input  wire cpxcs_pkg::cpxcs_live_t  live,
	input  wire logic                    fifo_elast_lsb_default,
	input  wire logic                    fifo_elast_default_load,
	input  wire logic [3:0]              line_pair_out_in,
	input  wire logic [4:0]              tx_code_in,
	input  wire logic                    tx_en_in,
	input  wire logic [3:0]              txd_nibble_in,
	output cpxcs_pkg::cpxcs_ctrl_t       ctrl,
	output logic [3:0]                   line_pair_outputs,
	output logic [3:0]                   line_pair_outputs_oe,
	output logic [4:0]                   scrambler_tx_code,
	output logic                         scrambler_tx_valid,
	output logic                         framing_enable,
	output logic                         rx_deliver_5b,
	output logic                         rx_align_enable,
	output logic                         scrambler_enable,
	output logic                         mlt3_enable,
	output logic                         auto_xover_enable,
	output logic                         scrambler_load_ones,
	input  wire logic                    activity_normal,
	input  wire logic                    activity_traffic,
	input  wire logic                    transmit_normal,
	input  wire logic                    transmit_traffic,
	input  wire logic [1:0]              other_led_normal,
	output logic                         activity_indicator_out,
	output logic                         transmit_indicator_out,
	output logic [1:0]                   other_led_out
);
	logic [15:0] ctrl_q;
	logic [15:0] next_ctrl;
	logic        scr_pulse;
	cpxcs_pkg::cpxcs_events_t sticky;
	logic        remote_low;
	logic        local_low;
	logic        aw_held;
	logic        w_held;
	logic [15:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic        do_read;
	logic        status_read;
	logic [15:0] status_word;
	logic        led_on_eff;
	logic        led_off_eff;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a[15:2] == b[15:2]);
	endfunction

	// Write side: address and data are taken independently, then joined.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 16'h0000;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= cpxcs_pkg::AXI_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (hit(aw_addr, cpxcs_pkg::CTRL_BYTE_ADDR) ||
					hit(aw_addr, cpxcs_pkg::STATUS_BYTE_ADDR)) ?
					cpxcs_pkg::AXI_OKAY : cpxcs_pkg::AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register. Reserved bits store nothing and read as zero,
	// so read-modify-write by software is harmless.
	always_comb begin
		next_ctrl = ctrl_q;
		if (do_write && hit(aw_addr, cpxcs_pkg::CTRL_BYTE_ADDR)) begin
			if (w_strb[0])
				next_ctrl[7:0] = w_data[7:0];
			if (w_strb[1])
				next_ctrl[15:8] = w_data[15:8];
			next_ctrl = next_ctrl & cpxcs_pkg::CTRL_WMASK; // [RULE_12]
		end
		next_ctrl[cpxcs_pkg::BIT_SCR_RST] = 1'b0; // [RULE_08]
		if (fifo_elast_default_load)
			next_ctrl[cpxcs_pkg::BIT_FIFO_LSB] = fifo_elast_lsb_default; // [RULE_13]
	end

	assign scr_pulse = do_write && hit(aw_addr, cpxcs_pkg::CTRL_BYTE_ADDR) &&
		w_strb[0] && w_data[cpxcs_pkg::BIT_SCR_RST];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= cpxcs_pkg::CTRL_RESET;
			scrambler_load_ones <= 1'b0;
		end else if (clk_en) begin
			ctrl_q <= next_ctrl;
			scrambler_load_ones <= scr_pulse; // [RULE_08]
		end
	end

	assign ctrl = '{no_auto_xover:    ctrl_q[cpxcs_pkg::BIT_NO_XOVER],
		tx_disable:       ctrl_q[cpxcs_pkg::BIT_TX_DIS],
		bypass_4b5b:      ctrl_q[cpxcs_pkg::BIT_BYP_4B5B],
		bypass_scrambler: ctrl_q[cpxcs_pkg::BIT_BYP_SCR],
		bypass_mlt3:      ctrl_q[cpxcs_pkg::BIT_BYP_MLT3],
		bypass_align:     ctrl_q[cpxcs_pkg::BIT_BYP_ALIGN],
		scrambler_load:   scrambler_load_ones,
		led_traffic:      ctrl_q[cpxcs_pkg::BIT_LED_TRAF],
		led_on:           ctrl_q[cpxcs_pkg::BIT_LED_ON],
		led_off:          ctrl_q[cpxcs_pkg::BIT_LED_OFF],
		fifo_elast_lsb:   ctrl_q[cpxcs_pkg::BIT_FIFO_LSB]};

	assign auto_xover_enable = !ctrl.no_auto_xover; // [RULE_01]
	assign scrambler_enable  = !ctrl.bypass_scrambler; // [RULE_05]
	assign mlt3_enable       = !ctrl.bypass_mlt3; // [RULE_06]
	assign rx_align_enable   = !ctrl.bypass_align; // [RULE_07]
	assign rx_deliver_5b     = ctrl.bypass_4b5b; // [RULE_04]
	assign framing_enable    = !ctrl.bypass_4b5b; // [RULE_03]

	// Line drivers and transmit code path are registered data outputs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_pair_outputs    <= 4'h0;
			line_pair_outputs_oe <= 4'h0;
			scrambler_tx_code    <= 5'h00;
			scrambler_tx_valid   <= 1'b0;
		end else if (clk_en) begin
			line_pair_outputs    <= line_pair_out_in;
			line_pair_outputs_oe <= ctrl.tx_disable ? 4'h0 : 4'hF; // [RULE_02]
			if (ctrl.bypass_4b5b) begin
				scrambler_tx_code  <= tx_code_in; // [RULE_03]
				scrambler_tx_valid <= 1'b1;
			end else begin
				scrambler_tx_code  <= {1'b0, txd_nibble_in};
				scrambler_tx_valid <= tx_en_in;
			end
		end
	end

	// LED override: off beats on because a dark board is the safe default.
	assign led_off_eff = ctrl.led_off; // [RULE_23]
	assign led_on_eff  = ctrl.led_on && !ctrl.led_off; // [RULE_23]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			activity_indicator_out <= 1'b0;
			transmit_indicator_out <= 1'b0;
			other_led_out          <= 2'h0;
		end else if (clk_en) begin
			if (led_off_eff) begin
				activity_indicator_out <= 1'b0; // [RULE_11]
				transmit_indicator_out <= 1'b0;
				other_led_out          <= 2'h0;
			end else if (led_on_eff) begin
				activity_indicator_out <= 1'b1; // [RULE_10]
				transmit_indicator_out <= 1'b1;
				other_led_out          <= 2'h3;
			end else begin
				activity_indicator_out <= ctrl.led_traffic ?
					activity_traffic : activity_normal; // [RULE_09]
				transmit_indicator_out <= ctrl.led_traffic ?
					transmit_traffic : transmit_normal;
				other_led_out          <= other_led_normal;
			end
		end
	end

	// Read side: one read at a time, answered one cycle after acceptance.
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign status_read = do_read && hit(s_axi_araddr, cpxcs_pkg::STATUS_BYTE_ADDR);

	assign status_word = {sticky.selector_mismatch, // [RULE_14]
		live.speed_downgraded, // [RULE_15]
		live.crossover_mdi, // [RULE_16]
		1'b0,
		!remote_low && live.remote_rx_ok, // [RULE_17]
		!local_low && live.local_rx_ok,
		live.descr_locked, // [RULE_18]
		live.link_pass,
		sticky.crc_err, // [RULE_19]
		sticky.carrier_ext_err, sticky.bad_ssd, sticky.bad_esd, // [RULE_20]
		sticky.invalid_code, sticky.tx_err_code, sticky.lock_lost, // [RULE_21]
		sticky.mlt3_err}; // [RULE_22]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= cpxcs_pkg::AXI_OKAY;
		end else if (clk_en) begin
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= cpxcs_pkg::AXI_OKAY;
				if (hit(s_axi_araddr, cpxcs_pkg::CTRL_BYTE_ADDR))
					s_axi_rdata <= {16'h0000, ctrl_q}; // [RULE_08]
				else if (status_read)
					s_axi_rdata <= {16'h0000, status_word};
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= cpxcs_pkg::AXI_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Latched bits: the read clears, but a same-cycle event sets again.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sticky     <= '0;
			remote_low <= 1'b0;
			local_low  <= 1'b0;
		end else if (clk_en) begin
			sticky     <= (status_read ? '0 : sticky) | events; // [RULE_24]
			remote_low <= (status_read ? 1'b0 : remote_low) |
				!live.remote_rx_ok; // [RULE_17]
			local_low  <= (status_read ? 1'b0 : local_low) |
				!live.local_rx_ok; // [RULE_24]
		end
	end

	sequence s_status_take;
		clk_en && status_read;
	endsequence

	chk_scr_selfclear: assert property ( // [RULE_08]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && scrambler_load_ones |=> !scrambler_load_ones || $past(scr_pulse))
		else $error("Scrambler load stuck high.");
	chk_scr_pulse: assert property ( // [RULE_08]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && scr_pulse |=> scrambler_load_ones)
		else $error("Scrambler load pulse missing.");
	chk_led_off_wins: assert property ( // [RULE_23]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && ctrl.led_off |=> !activity_indicator_out && !transmit_indicator_out)
		else $error("LED not off under force-off.");
	chk_led_on: assert property ( // [RULE_10]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && ctrl.led_on && !ctrl.led_off |=> activity_indicator_out)
		else $error("LED not on under force-on.");
	chk_led_traffic: assert property ( // [RULE_09]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && !ctrl.led_off && !ctrl.led_on && ctrl.led_traffic
		|=> activity_indicator_out == $past(activity_traffic))
		else $error("Activity LED not in traffic mode.");
	chk_tx_disable: assert property ( // [RULE_02]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && ctrl.tx_disable |=> line_pair_outputs_oe == 4'h0)
		else $error("Line pairs driven while disabled.");
	chk_tx_raw_code: assert property ( // [RULE_03]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && ctrl.bypass_4b5b |=> scrambler_tx_valid)
		else $error("Raw 5B code not passed under bypass.");
	chk_rx_bypass: assert property ( // [RULE_04]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && ctrl.bypass_4b5b |-> rx_deliver_5b && !framing_enable)
		else $error("Receive path not delivering 5B codes.");
	chk_reserved_zero: assert property ( // [RULE_12]
		@(posedge aclk) disable iff (!aresetn)
		clk_en |=> (ctrl_q & 16'h9806) == 16'h0000)
		else $error("Reserved control bits hold a value.");
	chk_event_latch: assert property ( // [RULE_24]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && events.crc_err |=> sticky.crc_err)
		else $error("CRC event not latched.");
	chk_event_wins: assert property ( // [RULE_24]
		@(posedge aclk) disable iff (!aresetn)
		s_status_take ##0 events.mlt3_err |=> sticky.mlt3_err)
		else $error("Event lost to a same-cycle read.");
	chk_sticky_hold: assert property ( // [RULE_20]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && sticky.bad_ssd && !status_read |=> sticky.bad_ssd)
		else $error("Latched bit lost without read.");
	chk_rx_low_latch: assert property ( // [RULE_17]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && !live.local_rx_ok |=> local_low)
		else $error("Local receiver not-OK not latched.");
	chk_remote_latch: assert property ( // [RULE_17]
		@(posedge aclk) disable iff (!aresetn)
		clk_en && !live.remote_rx_ok |=> remote_low)
		else $error("Remote receiver not-OK not latched.");
	chk_live_link: assert property ( // [RULE_18]
		@(posedge aclk) disable iff (!aresetn)
		s_status_take |=> s_axi_rdata[8] == $past(live.link_pass))
		else $error("Link status not shown live.");
	chk_read_clear: assert property ( // [RULE_21]
		@(posedge aclk) disable iff (!aresetn)
		s_status_take ##0 events == '0 |=> sticky == '0)
		else $error("Read did not clear latched bits.");
endmodule

/* File: tb/cpxcs_host.sv */
// Purpose: AXI4-Lite host model for the control and status pair.
// Assumes: Signals change only by NBA just after a rising edge.
// Notes:   Waits are unbounded; the bench watchdog ends a hang.
module cpxcs_host (
	input  wire logic   aclk,
	output logic [15:0] awaddr,
	output logic        awvalid,
	input  wire logic   awready,
	output logic [31:0] wdata,
	output logic [3:0]  wstrb,
	output logic        wvalid,
	input  wire logic   wready,
	input  wire logic   bvalid,
	output logic        bready,
	output logic [15:0] araddr,
	output logic        arvalid,
	input  wire logic   arready,
	input  wire logic   rvalid,
	output logic        rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Reserved control bits read back 0, so sending 0 preserves them.
	task automatic write(input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] s);
		bit ad;
		bit wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready) begin
				ad = 1;
				awvalid <= 1'h0;
			end
			if (!wd && wready) begin
				wd = 1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'h0;
	endtask
	task automatic read(input logic [15:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'h0;
	endtask
endmodule

/* File: tb/cpxcs_regs_bench.sv */
// Purpose: Self-checking bench for the copper control and status pair.
// Assumes: Outputs settle well within one bus cycle of their cause.
// Notes:   Bus answers are matched in order against a queue of notes.
module cpxcs_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] CA = cpxcs_pkg::CTRL_BYTE_ADDR;
	localparam logic [15:0] SA = cpxcs_pkg::STATUS_BYTE_ADDR;
	localparam logic [1:0]  OK = cpxcs_pkg::AXI_OKAY;
	localparam logic [1:0]  SE = cpxcs_pkg::AXI_SLVERR;
	logic        aclk, aresetn, clk_en, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready, fd, fl;
	logic        ten, an, at, tn, tt, aio, tio, stv, fen, r5b, ral;
	logic        sen, men, axe, slo;
	logic [15:0] awaddr, araddr, v;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, lpi, txn, lpoe;
	logic [1:0]  bresp, rresp, oln, olo;
	logic [4:0]  tci, stc;
	logic [33:0] exp_q[$];
	int          errors, cmp_count, pulses, n_load;
	cpxcs_pkg::cpxcs_events_t ev;
	cpxcs_pkg::cpxcs_live_t   lv;
	cpxcs_pkg::cpxcs_ctrl_t   ctl;
	cpxcs_regs u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .events(ev), .live(lv),
		.fifo_elast_lsb_default(fd), .fifo_elast_default_load(fl),
		.line_pair_out_in(lpi), .tx_code_in(tci), .tx_en_in(ten),
		.txd_nibble_in(txn), .ctrl(ctl), .line_pair_outputs(),
		.line_pair_outputs_oe(lpoe), .scrambler_tx_code(stc),
		.scrambler_tx_valid(stv), .framing_enable(fen), .rx_deliver_5b(r5b),
		.rx_align_enable(ral), .scrambler_enable(sen), .mlt3_enable(men),
		.auto_xover_enable(axe), .scrambler_load_ones(slo),
		.activity_normal(an), .activity_traffic(at), .transmit_normal(tn),
		.transmit_traffic(tt), .other_led_normal(oln),
		.activity_indicator_out(aio), .transmit_indicator_out(tio),
		.other_led_out(olo));
	cpxcs_host u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		cmp_count++;
		if (got !== want) begin
			errors++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, want);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input logic [3:0] s, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		u_host.write(a, {16'h0, d}, s);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] r);
		exp_q.push_back({r, 16'h0, d});
		u_host.read(a);
	endtask
	function automatic logic [15:0] st(input logic [8:0] e,
		input logic [5:0] l, input logic [1:0] ok);
		return {e[8], l[5:4], 1'h0, l[3:2] & ok, l[1:0], e[0], e[7:1]};
	endfunction
	function automatic logic [3:0] led(input logic [15:0] c);
		if (c[3]) return 4'h0;
		if (c[4]) return 4'hF;
		return c[5] ? {at, tt, oln} : {an, tn, oln};
	endfunction
	task automatic print_verdict();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (slo === 1'h1) pulses++;
		if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
		if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
	end
	// A hung handshake ends here; normal runs finish far sooner.
	initial begin
		#100000;
		errors++;
		print_verdict();
	end
	initial begin
		aclk = 1'h0;
		clk_en = 1'h1;
		{aresetn, ev, lv, fd, fl, lpi, tci, ten, txn, an, at, tn, tt, oln} = '0;
		void'($urandom(32'hCC981674));
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rd(CA, 16'h0, OK);
		chk({axe, sen, men, ral, fen, r5b}, 6'h3E);
		for (int i = 0; i < 16; i++) begin
			v = 16'($urandom) & 16'h67F9;
			v[3] = v[3] & i[0];
			@(posedge aclk);
			{lpi, tci, ten, txn, an, at, tn, tt, oln} <= 20'($urandom);
			wr(CA, v, 4'h3, OK);
			n_load += v[6];
			rd(CA, v & 16'h67B9, OK);
			chk(ctl, {v[14:13], v[10:7], 1'h0, v[5:3], v[0]});
			chk(axe, !v[14]);
			chk(lpoe, {4{!v[13]}});
			chk({stc, stv}, v[10] ? {tci, 1'h1} : {1'h0, txn, ten});
			chk({fen, r5b}, {!v[10], v[10]});
			chk(sen, !v[9]);
			chk(men, !v[8]);
			chk(ral, !v[7]);
			chk({aio, tio, olo}, led(v));
		end
		// Only the upper byte lane is strobed, so the low byte must hold.
		wr(CA, 16'hFFFF, 4'h2, OK);
		rd(CA, {8'hFF, v[7:0]} & 16'h67B9, OK);
		@(posedge aclk);
		fd <= 1'h1;
		fl <= 1'h1;
		@(posedge aclk);
		fl <= 1'h0;
		v = {8'hFF, v[7:1], 1'h1} & 16'h67B9;
		rd(CA, v, OK);
		wr(16'h0008, 16'h0000, 4'h3, SE);
		wr(SA, 16'hFFFF, 4'h3, OK);
		rd(16'h0008, 16'h0, SE);
		rd(CA, v, OK);
		chk(pulses, n_load);
		@(posedge aclk);
		lv <= 6'($urandom) | 6'h0C;
		for (int i = 0; i < 9; i++) begin
			@(posedge aclk);
			ev <= 9'h1 << i;
			if (i == 0) lv[3:2] <= 2'h0;
			@(posedge aclk);
			ev <= 9'h0;
			lv[3:2] <= 2'h3;
			rd(SA, st(9'h1 << i, lv, (i == 0) ? 2'h0 : 2'h3), OK);
			rd(SA, st(9'h0, lv, 2'h3), OK);
		end
		print_verdict();
	end
endmodule
